// >>> pkg/io_slot_defines.svh
// constants for the io slot flag and interrupt logic
// assumes inclusion by the package and the bench
`ifndef IO_SLOT_DEFINES_SVH
`define IO_SLOT_DEFINES_SVH

`define IO_SLOT_ADDR_W 8
`define IO_SLOT_DATA_W 32
`define IO_SLOT_WORD_W 16
`define IO_SLOT_WORD_ZERO 16'h0000

// register byte offsets
`define IO_SLOT_OFS_STATUS 8'h00
`define IO_SLOT_OFS_IN_DATA 8'h04
`define IO_SLOT_OFS_OUT_DATA 8'h08
`define IO_SLOT_OFS_EVENTS 8'h0C

// status field positions
`define IO_SLOT_ST_CONTROL 0
`define IO_SLOT_ST_COMMAND 1
`define IO_SLOT_ST_FLAG_BUF 2
`define IO_SLOT_ST_FLAG 3
`define IO_SLOT_ST_IRQ 4
`define IO_SLOT_ST_ADDRESSED 5

// event field positions (write one to clear)
`define IO_SLOT_EV_END_BLOCK 0
`define IO_SLOT_EV_OUT_WORD 1
`define IO_SLOT_EV_IN_WORD 2
`define IO_SLOT_EV_W 3

// reset values
`define IO_SLOT_IN_DATA_RST 16'h0000
`define IO_SLOT_EV_RST 3'h0

// axi responses
`define IO_SLOT_RESP_OKAY 2'h0
`define IO_SLOT_RESP_SLVERR 2'h2

`endif

// >>> pkg/io_slot_pkg.sv
// types for the io slot flag and interrupt logic
// assumes the defines header is on the include path
`include "io_slot_defines.svh"

package io_slot_pkg;

  typedef logic [`IO_SLOT_ADDR_W-1:0] addr_t;
  typedef logic [`IO_SLOT_DATA_W-1:0] data_t;
  typedef logic [`IO_SLOT_WORD_W-1:0] word_t;
  typedef logic [1:0] resp_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic have_aw;
    logic have_w;
    addr_t waddr;
    data_t wdata;
    logic [3:0] wstrb;
    logic wr_en;
    logic bvalid;
    resp_t bresp;
    logic rvalid;
    data_t rdata;
    resp_t rresp;
  } axil_state_t;

  typedef struct packed {
    logic control;
    logic command;
    logic flag_buf;
    logic flag;
    logic irq;
    logic xfer_strobe_prev;
    word_t in_data;
    word_t out_data;
    logic [`IO_SLOT_EV_W-1:0] events;
    logic skip;
    logic prio_out;
    logic flag_digit_out;
    logic irq_out;
    logic svc_req;
    word_t bus_out;
    logic bus_oe_n;
  } slot_state_t;

endpackage : io_slot_pkg

// >>> rtl/axil_reg_slave.sv
// axi4-lite slave front end for a small word register file
// assumes one write and one read in flight at most; read data comes
// combinationally from the owner for the address on araddr
`timescale 1ns/1ps

module axil_reg_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire io_slot_pkg::addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire io_slot_pkg::data_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output io_slot_pkg::resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire io_slot_pkg::addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output io_slot_pkg::data_t s_axi_rdata,
  output io_slot_pkg::resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output io_slot_pkg::addr_t wr_addr,
  output io_slot_pkg::data_t wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  input wire io_slot_pkg::data_t rd_data,
  input wire logic rd_ok
);
  import io_slot_pkg::*;

  axil_state_t s_r;
  axil_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_en = 1'b0;
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.have_aw = 1'b1;
      s_nxt.awready = 1'b0;
      s_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.have_w = 1'b1;
      s_nxt.wready = 1'b0;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    // both halves held: commit and answer
    if (s_r.have_aw && s_r.have_w && !s_r.bvalid) begin
      s_nxt.wr_en = 1'b1;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_ok ? `IO_SLOT_RESP_OKAY : `IO_SLOT_RESP_SLVERR;
      s_nxt.have_aw = 1'b0;
      s_nxt.have_w = 1'b0;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end
    // read: answer the cycle after the address is taken
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_data;
      s_nxt.rresp = rd_ok ? `IO_SLOT_RESP_OKAY : `IO_SLOT_RESP_SLVERR;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign wr_en = s_r.wr_en;
  assign wr_addr = s_r.waddr;
  assign wr_data = s_r.wdata;
  assign wr_strb = s_r.wstrb;

endmodule : axil_reg_slave

// >>> rtl/io_slot_flag_interrupt_logic.sv
// backplane control logic of a plug-in io card: select decode, control,
// command, flag buffer, flag and interrupt request flip-flops, skip test,
// priority chain, channel service request and strobed data transfers
// assumes all backplane inputs are synchronous to clk and active high
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module io_slot_flag_interrupt_logic (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // backplane selection and commands
  input wire logic io_group_active,
  input wire logic select_high_digit,
  input wire logic select_low_digit,
  input wire logic clear_control_cmd,
  input wire logic set_control_cmd,
  input wire logic clear_flag_cmd,
  input wire logic set_flag_cmd,
  input wire logic skip_if_set_cmd,
  input wire logic skip_if_clear_cmd,
  input wire logic global_control_reset,
  input wire logic power_on_flag_preset,
  input wire logic flag_set_timing,
  input wire logic request_set_timing,
  input wire logic global_interrupt_enable,
  input wire logic interrupt_acknowledge,
  input wire logic priority_in,
  input wire logic end_of_block_transfer,
  // data strobes
  input wire logic data_input_strobe,
  input wire logic data_output_strobe,
  input wire logic block_input_strobe,
  input wire logic block_output_strobe,
  input wire logic block_transfer_strobe,
  // io bus, two-way
  input wire io_slot_pkg::word_t io_bus_in,
  output io_slot_pkg::word_t io_bus_out,
  output logic io_bus_oe_n,
  // backplane answers
  output logic skip_line,
  output logic priority_out,
  output logic flag_line_high_digit,
  output logic request_line_low_digit,
  output logic channel_service_request,
  // peripheral side
  input wire logic device_flag,
  // register bus
  input wire io_slot_pkg::addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire io_slot_pkg::data_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output io_slot_pkg::resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire io_slot_pkg::addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output io_slot_pkg::data_t s_axi_rdata,
  output io_slot_pkg::resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import io_slot_pkg::*;

  slot_state_t s_r;
  slot_state_t s_nxt;

  logic wr_en;
  addr_t wr_addr;
  data_t wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  data_t rd_data;
  logic rd_ok;

  ////////////////////////////////////////////////////////////////////
  // register bus front end
  axil_reg_slave u_axil (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  ////////////////////////////////////////////////////////////////////
  // register read and write decode
  logic addressed;
  assign addressed = io_group_active && select_high_digit && select_low_digit;

  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `IO_SLOT_OFS_STATUS: begin
        rd_data[`IO_SLOT_ST_CONTROL] = s_r.control;
        rd_data[`IO_SLOT_ST_COMMAND] = s_r.command;
        rd_data[`IO_SLOT_ST_FLAG_BUF] = s_r.flag_buf;
        rd_data[`IO_SLOT_ST_FLAG] = s_r.flag;
        rd_data[`IO_SLOT_ST_IRQ] = s_r.irq;
        rd_data[`IO_SLOT_ST_ADDRESSED] = addressed;
      end
      `IO_SLOT_OFS_IN_DATA: rd_data[`IO_SLOT_WORD_W-1:0] = s_r.in_data;
      `IO_SLOT_OFS_OUT_DATA: rd_data[`IO_SLOT_WORD_W-1:0] = s_r.out_data;
      `IO_SLOT_OFS_EVENTS: rd_data[`IO_SLOT_EV_W-1:0] = s_r.events;
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (wr_addr)
      `IO_SLOT_OFS_STATUS,
      `IO_SLOT_OFS_IN_DATA,
      `IO_SLOT_OFS_OUT_DATA,
      `IO_SLOT_OFS_EVENTS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // flip-flop network
  logic xfer_strobe_fall;
  logic block_out_take;
  logic out_take;
  logic drive_in;
  logic req_ok;
  logic [`IO_SLOT_EV_W-1:0] ev_set;
  logic [`IO_SLOT_EV_W-1:0] ev_clr;

  always_comb begin
    s_nxt = s_r;

    // control and command
    if (addressed && set_control_cmd) begin
      s_nxt.control = 1'b1;
      s_nxt.command = 1'b1;
    end else if (addressed && clear_control_cmd) begin
      s_nxt.control = 1'b0;
      s_nxt.command = 1'b0;
    end
    if (global_control_reset) begin
      s_nxt.control = 1'b0;
    end

    // flag buffer: sets win over clears
    if ((addressed && set_flag_cmd) || power_on_flag_preset || (device_flag && s_r.command)) begin
      s_nxt.flag_buf = 1'b1;
    end else if (addressed && (clear_flag_cmd || interrupt_acknowledge)) begin
      s_nxt.flag_buf = 1'b0;
    end

    // flag sets from the buffer at the timing pulse; only the clear command clears it
    if (flag_set_timing && s_r.flag_buf) begin
      s_nxt.flag = 1'b1;
    end else if (addressed && clear_flag_cmd) begin
      s_nxt.flag = 1'b0;
    end

    // interrupt request loads at the request pulse and clears whenever interrupts are disabled
    req_ok = s_r.control && s_r.flag_buf && s_r.flag && global_interrupt_enable && priority_in;
    if (request_set_timing) begin
      s_nxt.irq = req_ok;
    end else if (!global_interrupt_enable) begin
      s_nxt.irq = 1'b0;
    end

    // data transfers
    s_nxt.xfer_strobe_prev = block_transfer_strobe;
    xfer_strobe_fall = s_r.xfer_strobe_prev && !block_transfer_strobe;
    block_out_take = xfer_strobe_fall && block_output_strobe;
    out_take = addressed && data_output_strobe;
    if (out_take || block_out_take) begin
      s_nxt.out_data = io_bus_in;
    end
    drive_in = (addressed && data_input_strobe) || block_input_strobe;
    s_nxt.bus_oe_n = !drive_in;
    s_nxt.bus_out = drive_in ? s_r.in_data : `IO_SLOT_WORD_ZERO;

    // software writes
    ev_clr = '0;
    if (wr_en && wr_addr == `IO_SLOT_OFS_IN_DATA) begin
      if (wr_strb[0]) begin
        s_nxt.in_data[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
        s_nxt.in_data[15:8] = wr_data[15:8];
      end
    end
    if (wr_en && wr_addr == `IO_SLOT_OFS_EVENTS && wr_strb[0]) begin
      ev_clr = wr_data[`IO_SLOT_EV_W-1:0];
    end

    // sticky events, set wins over clear
    ev_set = '0;
    ev_set[`IO_SLOT_EV_END_BLOCK] = end_of_block_transfer;
    ev_set[`IO_SLOT_EV_OUT_WORD] = out_take || block_out_take;
    ev_set[`IO_SLOT_EV_IN_WORD] = block_input_strobe && block_transfer_strobe;
    s_nxt.events = (s_r.events & ~ev_clr) | ev_set;

    // registered backplane answers
    s_nxt.skip = addressed && ((s_r.flag && skip_if_set_cmd) || (!s_r.flag && skip_if_clear_cmd));
    s_nxt.prio_out = priority_in && !s_nxt.irq;
    s_nxt.flag_digit_out = s_nxt.irq && s_nxt.flag;
    s_nxt.irq_out = s_nxt.irq;
    s_nxt.svc_req = s_nxt.flag;
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.in_data <= `IO_SLOT_IN_DATA_RST;
      s_r.events <= `IO_SLOT_EV_RST;
      s_r.bus_oe_n <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign io_bus_out = s_r.bus_out;
  assign io_bus_oe_n = s_r.bus_oe_n;
  assign skip_line = s_r.skip;
  assign priority_out = s_r.prio_out;
  assign flag_line_high_digit = s_r.flag_digit_out;
  assign request_line_low_digit = s_r.irq_out;
  assign channel_service_request = s_r.svc_req;

endmodule : io_slot_flag_interrupt_logic

// >>> sim/io_slot_host_model.sv
// host io section model: select code decode and io bus level
// assumes the bench gives the instruction select code and the host word
`timescale 1ns/1ps

module io_slot_host_model import io_slot_pkg::*; #(
  parameter logic [5:0] SLOT = 6'h15
) (
  input wire logic clk,
  input wire logic [5:0] sel_code,
  input wire io_slot_pkg::word_t host_word,
  input wire logic host_drive,
  input wire io_slot_pkg::word_t card_word,
  input wire logic card_oe_n,
  output logic sel_high,
  output logic sel_low,
  output io_slot_pkg::word_t bus
);
  word_t last_r = 16'h0000;

  ////////////////////////////////////////////////////////////////
  assign sel_high = sel_code[5:3] == SLOT[5:3];
  assign sel_low = sel_code[2:0] == SLOT[2:0];
  // released bus shows the inverse of its last level
  assign bus = !card_oe_n ? card_word : (host_drive ? host_word : ~last_r);

  always_ff @(posedge clk) begin
    last_r <= bus;
  end
endmodule : io_slot_host_model

// >>> sim/io_slot_flag_interrupt_logic_sva.sv
// checker for the backplane outputs of the io slot logic
// assumes ce held high and the top module ports only
`timescale 1ns/1ps

module io_slot_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic io_group_active,
  input wire logic select_high_digit,
  input wire logic select_low_digit,
  input wire logic skip_if_set_cmd,
  input wire logic skip_if_clear_cmd,
  input wire logic flag_set_timing,
  input wire logic request_set_timing,
  input wire logic global_interrupt_enable,
  input wire logic priority_in,
  input wire logic data_input_strobe,
  input wire logic block_input_strobe,
  input wire io_slot_pkg::word_t io_bus_out,
  input wire logic io_bus_oe_n,
  input wire logic skip_line,
  input wire logic priority_out,
  input wire logic flag_line_high_digit,
  input wire logic request_line_low_digit,
  input wire logic channel_service_request
);
  import io_slot_pkg::*;
  logic sel;
  assign sel = io_group_active && select_high_digit && select_low_digit;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////
  a_skip_level: assert property ($past(rst_n) |->
    skip_line == $past(sel && (channel_service_request ? skip_if_set_cmd : skip_if_clear_cmd)))
    else $error("skip line wrong");
  a_prio_chain: assert property (priority_out |->
    $past(priority_in) && !request_line_low_digit) else $error("priority out wrong");
  a_irq_digits: assert property (flag_line_high_digit |-> request_line_low_digit)
    else $error("flag digit without request");
  a_irq_rise: assert property ($rose(request_line_low_digit) |->
    $past(request_set_timing && global_interrupt_enable && priority_in)) else $error("request set wrong");
  a_irq_gate: assert property (!global_interrupt_enable |=> !request_line_low_digit)
    else $error("request not gated");
  a_bus_drive: assert property ($past(rst_n) |->
    io_bus_oe_n == !$past((sel && data_input_strobe) || block_input_strobe)) else $error("bus enable wrong");
  a_bus_idle: assert property (io_bus_oe_n |-> io_bus_out == 16'h0000)
    else $error("idle bus word not zero");
  a_srq_rise: assert property ($rose(channel_service_request) |-> $past(flag_set_timing))
    else $error("flag set off timing pulse");
  c_skip: cover property (skip_line);
  c_irq: cover property (request_line_low_digit);
  c_drive: cover property (!io_bus_oe_n);
endmodule : io_slot_sva

bind io_slot_flag_interrupt_logic io_slot_sva chk_i (.*);

// >>> sim/io_slot_flag_interrupt_logic_bench.sv
// bench for the io slot logic: command rows, interrupt, skip, strobes, registers
// assumes the host model decodes the select code and resolves the io bus
`timescale 1ns/1ps
`include "io_slot_defines.svh"

module io_slot_flag_interrupt_logic_bench;
  import io_slot_pkg::*;
  logic clk, rst_n, ce, io_group_active, skip_if_set_cmd, skip_if_clear_cmd, request_set_timing;
  logic global_interrupt_enable, priority_in, end_of_block_transfer, data_input_strobe, data_output_strobe;
  logic block_input_strobe, block_output_strobe, block_transfer_strobe, host_drive;
  logic clear_control_cmd, set_control_cmd, clear_flag_cmd, set_flag_cmd, global_control_reset;
  logic power_on_flag_preset, flag_set_timing, interrupt_acknowledge, device_flag;
  logic select_high_digit, select_low_digit, io_bus_oe_n, skip_line, priority_out;
  logic flag_line_high_digit, request_line_low_digit, channel_service_request;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [5:0] sel_code;
  logic [8:0] cmd;
  word_t io_bus_in, io_bus_out, host_word;
  addr_t s_axi_awaddr, s_axi_araddr;
  data_t s_axi_wdata, s_axi_rdata;
  resp_t s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int tests_run = 0;
  // addressed, {flag tim,set flag,clr flag,set ctl,clr ctl,ctl reset,preset,ack,dev flag}, status[4:0]
  logic [14:0] rows [13] = '{{1'h1, 9'h020, 5'h03}, {1'h1, 9'h080, 5'h07}, {1'h0, 9'h010, 5'h07},
    {1'h0, 9'h008, 5'h06}, {1'h1, 9'h040, 5'h02}, {1'h0, 9'h004, 5'h06}, {1'h0, 9'h100, 5'h0E},
    {1'h1, 9'h002, 5'h0A}, {1'h1, 9'h040, 5'h02}, {1'h1, 9'h010, 5'h00}, {1'h1, 9'h020, 5'h03},
    {1'h0, 9'h001, 5'h07}, {1'h1, 9'h010, 5'h04}};
  assign {flag_set_timing, set_flag_cmd, clear_flag_cmd, set_control_cmd, clear_control_cmd,
    global_control_reset, power_on_flag_preset, interrupt_acknowledge, device_flag} = cmd;

  io_slot_flag_interrupt_logic dut (.*);
  io_slot_host_model host (.clk(clk), .sel_code(sel_code), .host_word(host_word), .host_drive(host_drive),
    .card_word(io_bus_out), .card_oe_n(io_bus_oe_n), .sel_high(select_high_digit),
    .sel_low(select_low_digit), .bus(io_bus_in));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic hang();
    num_errors++;
    conclude();
  endtask : hang

  task automatic chk(input data_t got, input data_t exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t word %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t bit %b want %b", $time, got, exp);
    end
  endtask : chkb

  task automatic wr(input addr_t a, input data_t d, output resp_t r);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 50) hang();
    @(posedge clk);
  endtask : wr

  task automatic rd(input addr_t a, output data_t d, output resp_t r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 50) hang();
    @(posedge clk);
  endtask : rd

  task automatic skip_case(input logic [5:0] code, input logic s, input logic c, input logic e);
    sel_code <= code;
    skip_if_set_cmd <= s;
    skip_if_clear_cmd <= c;
    @(posedge clk);
    skip_if_set_cmd <= 1'b0;
    skip_if_clear_cmd <= 1'b0;
    @(posedge clk);
    chkb(skip_line, e);
  endtask : skip_case

  ////////////////////////////////////////////////////////////////
  initial begin
    data_t d;
    resp_t r;
    {clk, rst_n, io_group_active, skip_if_set_cmd, skip_if_clear_cmd, request_set_timing, global_interrupt_enable,
      priority_in, end_of_block_transfer, data_input_strobe, data_output_strobe, block_input_strobe,
      block_output_strobe, block_transfer_strobe, host_drive, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
      s_axi_arvalid, s_axi_rready, sel_code, cmd, host_word, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`IO_SLOT_OFS_STATUS, d, r);
    chk(d, 32'h00000000);
    io_group_active <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      sel_code <= rows[i][14] ? 6'h15 : 6'h00;
      cmd <= rows[i][13:5];
      @(posedge clk);
      cmd <= 9'h000;
      @(posedge clk);
      rd(`IO_SLOT_OFS_STATUS, d, r);
      chk(d & 32'h0000001F, {27'h0000000, rows[i][4:0]});
    end
    sel_code <= 6'h15;
    cmd <= 9'h020;
    @(posedge clk);
    cmd <= 9'h100;
    @(posedge clk);
    cmd <= 9'h000;
    global_interrupt_enable <= 1'b1;
    priority_in <= 1'b1;
    request_set_timing <= 1'b1;
    @(posedge clk);
    request_set_timing <= 1'b0;
    @(posedge clk);
    chkb(request_line_low_digit, 1'b1);
    chkb(flag_line_high_digit, 1'b1);
    chkb(priority_out, 1'b0);
    chkb(channel_service_request, 1'b1);
    global_interrupt_enable <= 1'b0;
    repeat (2) @(posedge clk);
    chkb(request_line_low_digit, 1'b0);
    chkb(priority_out, 1'b1);
    priority_in <= 1'b0;
    global_interrupt_enable <= 1'b1;
    request_set_timing <= 1'b1;
    @(posedge clk);
    request_set_timing <= 1'b0;
    @(posedge clk);
    chkb(request_line_low_digit, 1'b0);
    chkb(priority_out, 1'b0);
    skip_case(6'h15, 1'b1, 1'b0, 1'b1);
    skip_case(6'h15, 1'b0, 1'b1, 1'b0);
    skip_case(6'h10, 1'b1, 1'b0, 1'b0);
    sel_code <= 6'h15;
    cmd <= 9'h040;
    @(posedge clk);
    cmd <= 9'h000;
    skip_case(6'h15, 1'b0, 1'b1, 1'b1);
    chkb(channel_service_request, 1'b0);
    wr(`IO_SLOT_OFS_IN_DATA, 32'h0000A5C3, r);
    data_input_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    chkb(io_bus_oe_n, 1'b0);
    chk({16'h0000, io_bus_out}, 32'h0000A5C3);
    sel_code <= 6'h10;
    repeat (2) @(posedge clk);
    chkb(io_bus_oe_n, 1'b1);
    data_input_strobe <= 1'b0;
    sel_code <= 6'h15;
    host_word <= 16'h3C5A;
    host_drive <= 1'b1;
    data_output_strobe <= 1'b1;
    @(posedge clk);
    data_output_strobe <= 1'b0;
    @(posedge clk);
    rd(`IO_SLOT_OFS_OUT_DATA, d, r);
    chk(d, 32'h00003C5A);
    host_word <= 16'h1234;
    block_output_strobe <= 1'b1;
    block_transfer_strobe <= 1'b1;
    @(posedge clk);
    block_transfer_strobe <= 1'b0;
    @(posedge clk);
    block_output_strobe <= 1'b0;
    host_drive <= 1'b0;
    @(posedge clk);
    rd(`IO_SLOT_OFS_OUT_DATA, d, r);
    chk(d, 32'h00001234);
    block_input_strobe <= 1'b1;
    @(posedge clk);
    block_transfer_strobe <= 1'b1;
    @(posedge clk);
    chkb(io_bus_oe_n, 1'b0);
    block_transfer_strobe <= 1'b0;
    block_input_strobe <= 1'b0;
    end_of_block_transfer <= 1'b1;
    @(posedge clk);
    end_of_block_transfer <= 1'b0;
    @(posedge clk);
    rd(`IO_SLOT_OFS_EVENTS, d, r);
    chk(d, 32'h00000007);
    wr(`IO_SLOT_OFS_EVENTS, 32'h00000007, r);
    rd(`IO_SLOT_OFS_EVENTS, d, r);
    chk(d, 32'h00000000);
    rd(8'h40, d, r);
    chk({30'h00000000, r}, {30'h00000000, `IO_SLOT_RESP_SLVERR});
    wr(8'h44, 32'h00000001, r);
    chk({30'h00000000, r}, {30'h00000000, `IO_SLOT_RESP_SLVERR});
    // mid-run reset: outputs idle at first edge after release
    rst_n <= 1'b0;
    priority_in <= 1'b1;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chkb(priority_out, 1'b0);
    chkb(io_bus_oe_n, 1'b1);
    rd(`IO_SLOT_OFS_STATUS, d, r);
    chk(d & 32'h0000001F, 32'h00000000);
    conclude();
  end
endmodule : io_slot_flag_interrupt_logic_bench
